/* design/eph_pkg.sv */
`default_nettype none
package eph_pkg;

	// Clock and device timing
	localparam int unsigned CLK_NS    = 25;
	localparam int unsigned T_WP_NS   = 100;
	localparam int unsigned T_WPH_NS  = 100;
	localparam int unsigned T_ACC_NS  = 250;
	localparam int unsigned T_OHZ_NS  = 50;
	localparam int unsigned T_BLC_US  = 200;
	localparam int unsigned T_WC_MS   = 10;

	localparam logic [3:0]  WP_CYC    = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0]  WPH_CYC   = 4'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0]  ACC_CYC   = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0]  OHZ_CYC   = 4'((T_OHZ_NS + CLK_NS - 1) / CLK_NS);
	// Longest byte-load gap rounds down
	localparam logic [15:0] BLC_CYC_DEF = 16'((T_BLC_US * 1000) / CLK_NS);
	localparam logic [18:0] WC_CYC_DEF  = 19'((T_WC_MS * 1000000) / CLK_NS);
	// Cycles from taking a write to its strobe falling, plus margin
	localparam logic [15:0] GUARD_CYC = 16'h0004;

	localparam logic [7:0]  PAGE_MAX  = 8'h80;
	localparam logic [3:0]  SEQ_ARM_FIRST = 4'h0;
	localparam logic [3:0]  SEQ_ARM_LAST  = 4'h2;
	localparam logic [3:0]  SEQ_DIS_FIRST = 4'h3;
	localparam logic [3:0]  SEQ_DIS_LAST  = 4'h8;
	localparam int unsigned SEQ_LEN   = 9;

	// Register offsets (byte addresses)
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_ADDR   = 8'h04;
	localparam logic [7:0]  REG_WDATA  = 8'h08;
	localparam logic [7:0]  REG_CMD    = 8'h0C;
	localparam logic [7:0]  REG_STATUS = 8'h10;

	// Field positions
	localparam int unsigned CTRL_PROT    = 0;
	localparam int unsigned ST_BUSY      = 0;
	localparam int unsigned ST_PENDING   = 1;
	localparam int unsigned ST_PAGE_OPEN = 2;
	localparam int unsigned ST_ERR_BUSY  = 3;
	localparam int unsigned ST_ERR_TO    = 4;
	localparam int unsigned ST_PCNT_LSB  = 8;
	localparam int unsigned ST_RDATA_LSB = 16;

	typedef enum logic [1:0] {
		OP_FLUSH,
		OP_WRITE,
		OP_READ,
		OP_DISARM
	} eph_op_e;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_WR_SETUP,
		ST_WR_LOW,
		ST_WR_HOLD,
		ST_WR_REC,
		ST_RD_ACC,
		ST_RD_GAP,
		ST_POLL_RD,
		ST_POLL_GAP
	} eph_state_e;

	typedef struct packed {
		eph_state_e  st;
		logic [3:0]  cnt;
		logic [18:0] pcnt;
		logic [15:0] blc;
		logic        prot_en;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  rdata;
		eph_op_e     op;
		logic        op_act;
		logic [3:0]  seq_idx;
		logic [3:0]  seq_last;
		logic        in_seq;
		logic        page_open;
		logic [8:0]  page_base;
		logic [7:0]  page_cnt;
		logic        pending;
		logic        last_t;
		logic        poll_have;
		logic        poll_done;
		logic        err_busy;
		logic        err_to;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        dq_oe;
		logic [15:0] pa;
		logic [7:0]  dq_o;
	} eph_state_s;

endpackage
`default_nettype wire

/* design/eph_host.sv */
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RULE_01] Device takes one to 128 byte loads before programming starts.
// [RULE_02] Every byte of one page carries the same page_select_address.
// [RULE_03] Any write may open a page; up to 127 more bytes follow.
// [RULE_04] Each further strobe fall comes within 200 us of the previous one.
// [RULE_05] No strobe fall within 200 us starts device programming.
// [RULE_06] Page load time is unlimited while each gap stays in bounds.
// [RULE_07] While programming, last byte reads with bit 7 inverted.
// [RULE_08] After programming, bit 7 reads the true stored value.
// [RULE_09] While programming, alternating_status_bit flips on every read.
// [RULE_10] After programming the flip stops and new accesses are taken.
// [RULE_11] Device ignores strobe pulses shorter than about 10 ns.
// [RULE_12] No write while output drive is low or write strobe high.
// [RULE_13] Device ships with protection off, writes open.
// [RULE_14] First arm-sequence write sets protection until disarmed.
// [RULE_15] Protected device needs the arm sequence before each data write.
// [RULE_16] Arm sequence bytes are not stored in the array.
// [RULE_17] Protected write is three command writes then a page of data.
// [RULE_18] After that page completes the device is protected again.
// [RULE_19] Arm plus data sets protection, kept across power cycles.
// [RULE_20] Top address bit is ignored when matching command addresses.
// [RULE_21] Command sequence writes go back to back, no other accesses.
// [RULE_22] A six-write sequence clears protection to standard mode.
// [RULE_23] Write needs chip select and write strobe low, output drive high.
// [RULE_24] Address taken at later falling edge, data at earlier rising edge.
// [RULE_25] Read with output drive and chip select low; else bus released.
// [RULE_26] Command addresses and data are design parameters.
// [RULE_27] A byte from another page is not added to the page buffer.
module eph_host #(
	parameter logic [15:0]          BLC_CYC  = eph_pkg::BLC_CYC_DEF, // Byte-load window
	parameter logic [18:0]          WC_CYC   = eph_pkg::WC_CYC_DEF,  // Poll timeout
	// Arbitrary command table, entry 0 in the low bits; 0-2 arm, 3-8 disarm
	parameter logic [9*16-1:0]      SEQ_ADDR = {16'h5A5A, 16'h2A2A, 16'h5555,
		16'h5555, 16'h2AAA, 16'h5555, 16'h5555, 16'h2AAA, 16'h5555},
	parameter logic [9*8-1:0]       SEQ_DATA = {8'h20, 8'h55, 8'hAA,
		8'h80, 8'h55, 8'hAA, 8'hA0, 8'h55, 8'hAA}
) (
	input  wire logic               clk,       // 40 MHz clock
	input  wire logic               rst,       // Async reset, active high
	input  wire logic               en,        // Clock enable
	input  wire logic               psel,      // APB select
	input  wire logic               penable,   // APB enable
	input  wire logic               pwrite,    // APB write
	input  wire logic [7:0]         paddr,     // APB byte address
	input  wire logic [31:0]        pwdata,    // APB write data
	output logic [31:0]             prdata,    // APB read data
	output logic                    pready,    // APB ready
	output logic                    pslverr,   // APB error, unmapped
	output logic [15:0]             mem_addr,  // Memory address
	output logic                    mem_ce_n,  // Chip select, low active
	output logic                    mem_oe_n,  // Output drive, low active
	output logic                    mem_we_n,  // Write strobe, low active
	output logic [7:0]              mem_dq_o,  // Data bus out
	output logic                    mem_dq_oe, // Data bus drive enable
	input  wire logic [7:0]         mem_dq_i   // Data bus in
);
	import eph_pkg::*;

	eph_state_s s;
	eph_state_s next_s;
	logic       access;
	logic       wr;
	logic       mapped;

	assign access = psel & penable;
	assign wr     = access & pwrite;
	assign mapped = (paddr == REG_CTRL) || (paddr == REG_ADDR) || (paddr == REG_WDATA) ||
		(paddr == REG_CMD) || (paddr == REG_STATUS);

	always_comb
	begin
		next_s = s;
		// Register writes; error clears come before sets so a set wins
		if (wr)
		begin
			case (paddr)
				REG_CTRL:   next_s.prot_en = pwdata[CTRL_PROT];
				REG_ADDR:
				begin
					if (s.op_act)
						next_s.err_busy = 1'b1;
					else
						next_s.addr = pwdata[15:0];
				end
				REG_WDATA:
				begin
					if (s.op_act)
						next_s.err_busy = 1'b1;
					else
						next_s.wdata = pwdata[7:0];
				end
				REG_CMD:
				begin
					if (s.op_act)
						next_s.err_busy = 1'b1;
					else
					begin
						next_s.op_act = 1'b1;
						next_s.op     = eph_op_e'(pwdata[1:0]);
					end
				end
				REG_STATUS:
				begin
					if (pwdata[ST_ERR_BUSY])
						next_s.err_busy = 1'b0;
					if (pwdata[ST_ERR_TO])
						next_s.err_to = 1'b0;
				end
				default: ;
			endcase
		end
		// The device starts programming once the byte-load window lapses
		if (s.page_open)
		begin
			next_s.blc = s.blc + 16'h0001;
			if (s.blc >= BLC_CYC + GUARD_CYC) // RULE_05
			begin
				next_s.page_open = 1'b0;
				next_s.pending   = 1'b1;
				next_s.page_cnt  = 8'h00;
			end
		end
		if (s.st == ST_POLL_RD || s.st == ST_POLL_GAP)
			next_s.pcnt = s.pcnt + 19'h00001;
		case (s.st)
			ST_IDLE:
			begin
				if (s.op_act)
				begin
					if (s.page_open)
					begin
						// Join only same page, not full, well inside the window
						if (s.op == OP_WRITE && s.addr[15:7] == s.page_base && // RULE_02
							s.page_cnt != PAGE_MAX && s.blc < BLC_CYC - GUARD_CYC) // RULE_04
						begin
							next_s.in_seq = 1'b0;
							next_s.st     = ST_WR_SETUP; // RULE_03
						end
					end
					else if (s.pending)
					begin
						next_s.st        = ST_POLL_RD;
						next_s.cnt       = ACC_CYC - 4'h1;
						next_s.poll_have = 1'b0;
						next_s.poll_done = 1'b0;
						next_s.pcnt      = 19'h00000;
					end
					else
					begin
						case (s.op)
							OP_WRITE:
							begin
								next_s.in_seq   = s.prot_en; // RULE_15 RULE_17
								next_s.seq_idx  = SEQ_ARM_FIRST;
								next_s.seq_last = SEQ_ARM_LAST;
								next_s.st       = ST_WR_SETUP;
							end
							OP_DISARM:
							begin
								next_s.in_seq   = 1'b1; // RULE_22
								next_s.seq_idx  = SEQ_DIS_FIRST;
								next_s.seq_last = SEQ_DIS_LAST;
								next_s.st       = ST_WR_SETUP;
							end
							OP_READ:
							begin
								next_s.st  = ST_RD_ACC;
								next_s.cnt = ACC_CYC - 4'h1;
							end
							default: next_s.op_act = 1'b0;
						endcase
					end
				end
			end
			ST_WR_SETUP:
			begin
				next_s.st        = ST_WR_LOW;
				next_s.cnt       = WP_CYC - 4'h1;
				next_s.blc       = 16'h0000;
				next_s.page_open = 1'b1;
				if (!s.in_seq)
				begin
					if (s.page_cnt == 8'h00)
						next_s.page_base = s.addr[15:7];
					next_s.page_cnt = s.page_cnt + 8'h01;
				end
			end
			ST_WR_LOW:
			begin
				if (s.cnt == 4'h0)
					next_s.st = ST_WR_HOLD; // RULE_24
				else
					next_s.cnt = s.cnt - 4'h1;
			end
			ST_WR_HOLD:
			begin
				next_s.st  = ST_WR_REC;
				next_s.cnt = WPH_CYC - 4'h1;
			end
			ST_WR_REC:
			begin
				if (s.cnt != 4'h0)
					next_s.cnt = s.cnt - 4'h1;
				else if (s.in_seq && s.seq_idx != s.seq_last)
				begin
					next_s.seq_idx = s.seq_idx + 4'h1; // RULE_21
					next_s.st      = ST_WR_SETUP;
				end
				else if (s.in_seq && s.op == OP_DISARM)
				begin
					// Nothing may join the disarm load; wait it out, then poll
					next_s.page_cnt = PAGE_MAX;
					next_s.in_seq   = 1'b0;
					next_s.op_act   = 1'b0;
					next_s.st       = ST_IDLE;
				end
				else if (s.in_seq)
				begin
					next_s.in_seq = 1'b0;
					next_s.st     = ST_WR_SETUP;
				end
				else
				begin
					next_s.op_act = 1'b0;
					next_s.st     = ST_IDLE;
				end
			end
			ST_RD_ACC, ST_POLL_RD:
			begin
				if (s.cnt != 4'h0)
					next_s.cnt = s.cnt - 4'h1;
				else
				begin
					next_s.cnt = OHZ_CYC - 4'h1;
					if (s.st == ST_RD_ACC)
					begin
						next_s.rdata = mem_dq_i;
						next_s.st    = ST_RD_GAP;
					end
					else
					begin
						// Two reads with the same alternating bit mean done
						next_s.last_t    = mem_dq_i[6]; // RULE_09
						next_s.poll_have = 1'b1;
						next_s.poll_done = s.poll_have && (mem_dq_i[6] == s.last_t); // RULE_10
						next_s.st        = ST_POLL_GAP;
					end
				end
			end
			ST_RD_GAP:
			begin
				if (s.cnt != 4'h0)
					next_s.cnt = s.cnt - 4'h1;
				else
				begin
					next_s.op_act = 1'b0;
					next_s.st     = ST_IDLE;
				end
			end
			ST_POLL_GAP:
			begin
				if (s.cnt != 4'h0)
					next_s.cnt = s.cnt - 4'h1;
				else if (s.poll_done)
				begin
					next_s.pending = 1'b0;
					next_s.st      = ST_IDLE;
				end
				else
				begin
					next_s.st  = ST_POLL_RD;
					next_s.cnt = ACC_CYC - 4'h1;
				end
			end
			default: next_s.st = ST_IDLE;
		endcase
		// A dead device must not hang the controller forever
		if ((s.st == ST_POLL_RD || s.st == ST_POLL_GAP) && s.pcnt >= WC_CYC)
		begin
			next_s.err_to  = 1'b1;
			next_s.pending = 1'b0;
			next_s.st      = ST_IDLE;
		end
		// Pins follow the next state, so they come straight from flip-flops
		next_s.we_n  = (next_s.st != ST_WR_LOW);
		next_s.dq_oe = (next_s.st == ST_WR_SETUP) || (next_s.st == ST_WR_LOW) ||
			(next_s.st == ST_WR_HOLD);
		next_s.oe_n  = !((next_s.st == ST_RD_ACC) || (next_s.st == ST_POLL_RD)); // RULE_25
		next_s.ce_n  = !(next_s.dq_oe || !next_s.oe_n); // RULE_23
		if (next_s.st == ST_WR_SETUP)
		begin
			next_s.pa   = next_s.in_seq ? SEQ_ADDR[{next_s.seq_idx, 4'h0} +: 16] : s.addr; // RULE_26
			next_s.dq_o = next_s.in_seq ? SEQ_DATA[{next_s.seq_idx, 3'h0} +: 8] : s.wdata;
		end
		else if (!next_s.oe_n)
			next_s.pa = s.addr;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s      <= '0;
			s.ce_n <= 1'b1;
			s.oe_n <= 1'b1;
			s.we_n <= 1'b1;
		end
		else if (en)
			s <= next_s;
	end

	assign pready    = 1'b1;
	assign pslverr   = access & ~mapped;
	assign mem_addr  = s.pa;
	assign mem_ce_n  = s.ce_n;
	assign mem_oe_n  = s.oe_n;
	assign mem_we_n  = s.we_n;
	assign mem_dq_o  = s.dq_o;
	assign mem_dq_oe = s.dq_oe;

	always_comb
	begin
		prdata = 32'h0000_0000;
		case (paddr)
			REG_CTRL:   prdata[CTRL_PROT] = s.prot_en;
			REG_ADDR:   prdata[15:0]      = s.addr;
			REG_WDATA:  prdata[7:0]       = s.wdata;
			REG_CMD:    prdata[1:0]       = s.op;
			REG_STATUS:
			begin
				prdata[ST_BUSY]                     = s.op_act;
				prdata[ST_PENDING]                  = s.pending;
				prdata[ST_PAGE_OPEN]                = s.page_open;
				prdata[ST_ERR_BUSY]                 = s.err_busy;
				prdata[ST_ERR_TO]                   = s.err_to;
				prdata[ST_PCNT_LSB +: 8]            = s.page_cnt;
				prdata[ST_RDATA_LSB +: 8]           = s.rdata;
			end
			default: ;
		endcase
	end

	property p_wr_pins;
		@(posedge clk) disable iff (rst) !mem_we_n |-> !mem_ce_n && mem_oe_n && mem_dq_oe;
	endproperty
	a_wr_pins: assert property (p_wr_pins) else $error("strobe low without write pins"); // RULE_23

	property p_pulse;
		@(posedge clk) disable iff (rst) (en && $fell(mem_we_n)) |-> !mem_we_n [*4];
	endproperty
	a_pulse: assert property (p_pulse) else $error("write strobe pulse too short"); // RULE_11

	property p_window;
		@(posedge clk) disable iff (rst)
			($fell(mem_we_n) && $past(s.page_open)) |-> ($past(s.blc) < BLC_CYC);
	endproperty
	a_window: assert property (p_window) else $error("byte load past window"); // RULE_04

	property p_same_page;
		@(posedge clk) disable iff (rst)
			($fell(mem_we_n) && !s.in_seq && s.page_cnt > 8'h01) |-> (mem_addr[15:7] == s.page_base);
	endproperty
	a_same_page: assert property (p_same_page) else $error("page address changed"); // RULE_02

	property p_armed;
		@(posedge clk) disable iff (rst)
			($fell(mem_we_n) && s.prot_en && !s.in_seq && s.page_cnt == 8'h01 && s.op == OP_WRITE)
			|-> (s.seq_idx == SEQ_ARM_LAST);
	endproperty
	a_armed: assert property (p_armed) else $error("protected data without arm"); // RULE_15

	property p_seq_tight;
		@(posedge clk) disable iff (rst) s.in_seq |-> mem_oe_n;
	endproperty
	a_seq_tight: assert property (p_seq_tight) else $error("read inside sequence"); // RULE_21

	property p_disarm;
		@(posedge clk) disable iff (rst)
			($rose(s.in_seq) && s.op == OP_DISARM) |-> (s.seq_idx == SEQ_DIS_FIRST && s.seq_last == SEQ_DIS_LAST);
	endproperty
	a_disarm: assert property (p_disarm) else $error("disarm sequence not six writes"); // RULE_22

	property p_cmd_data;
		@(posedge clk) disable iff (rst)
			($fell(mem_we_n) && s.in_seq) |->
			(mem_addr == SEQ_ADDR[{s.seq_idx, 4'h0} +: 16] && mem_dq_o == SEQ_DATA[{s.seq_idx, 3'h0} +: 8]);
	endproperty
	a_cmd_data: assert property (p_cmd_data) else $error("command word mismatch"); // RULE_26

	property p_arm_count;
		@(posedge clk) disable iff (rst)
			($rose(s.in_seq) && s.op == OP_WRITE) |-> ##[1:40] (!s.in_seq && !mem_we_n);
	endproperty
	a_arm_count: assert property (p_arm_count) else $error("arm not followed by data"); // RULE_17

endmodule
`default_nettype wire

/* sim/eph_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module eph_mem_model #(
	parameter int           BLC_NS   = 2000, // Byte-load window
	parameter int           WC_NS    = 3000, // Programming time
	parameter logic [143:0] SEQ_ADDR = {16'h5A5A, 16'h2A2A, 16'h5555, 16'h5555,
		16'h2AAA, 16'h5555, 16'h5555, 16'h2AAA, 16'h5555},
	parameter logic [71:0]  SEQ_DATA = {8'h20, 8'h55, 8'hAA, 8'h80, 8'h55, 8'hAA,
		8'hA0, 8'h55, 8'hAA}
) (
	input  wire logic        ce_n,    // Chip select
	input  wire logic        oe_n,    // Output drive
	input  wire logic        we_n,    // Write strobe
	input  wire logic [15:0] addr,    // Address
	input  wire logic [7:0]  host_dq, // Host data
	input  wire logic        host_oe, // Host drive enable
	output logic [7:0]       bus      // Resolved data bus
);
	logic [7:0]  mem [int], pbuf [int];
	logic [7:0]  last_d = 8'h00, drv = 8'h5A;
	logic [15:0] la = 16'h0000;
	logic [8:0]  base = 9'h000;
	logic        prot = 1'b0;
	logic        unlock = 1'b0, arm_p = 1'b0, dis_p = 1'b0, busy = 1'b0, open = 1'b0;
	logic        tog = 1'b0;
	int          ka = 0, kd = 0;
	realtime     t_fall = 0, t_last = 0, t_prog = 0;
	wire         wr = !ce_n && !we_n && oe_n;
	wire         rd = !ce_n && !oe_n;
	assign bus = drv;

	function automatic logic hit(int i, logic [15:0] a, logic [7:0] d);
		return a[14:0] == SEQ_ADDR[i*16 +: 15] && d == SEQ_DATA[i*8 +: 8];
	endfunction

	// A partly matched command that breaks off is swallowed, as the real part may do
	task automatic take(input logic [15:0] a, input logic [7:0] d);
		logic ca, cd;
		ca = hit(ka, a, d);
		cd = hit(kd + 3, a, d);
		ka = ca ? ka + 1 : 0;
		kd = cd ? kd + 1 : 0;
		if (ka == 3)
		begin
			unlock = 1'b1;
			arm_p = 1'b1;
			ka = 0;
		end
		if (kd == 6)
		begin
			dis_p = 1'b1;
			kd = 0;
		end
		if (!ca && !cd && (prot && !unlock || pbuf.num() != 0 && a[15:7] != base))
			return;
		// The byte-load window runs from the strobe fall, not from data capture
		t_last = t_fall;
		open = 1'b1;
		if (ca || cd)
			return;
		if (pbuf.num() == 0)
			base = a[15:7];
		pbuf[a] = d;
		last_d = d;
	endtask

	always @(posedge wr)
	begin
		la = addr;
		t_fall = $realtime;
	end
	always @(negedge wr)
		if (!busy && $realtime - t_fall >= 10.0)
			take(la, host_dq);
	always @(negedge rd)
		if (busy)
			tog = ~tog;
	always #1
	begin
		if (open && !busy && $realtime - t_last > BLC_NS)
		begin
			busy = 1'b1;
			open = 1'b0;
			t_prog = $realtime;
		end
		if (busy && $realtime - t_prog >= WC_NS)
		begin
			foreach (pbuf[i])
				mem[i] = pbuf[i];
			prot = dis_p ? 1'b0 : (arm_p ? 1'b1 : prot);
			{unlock, arm_p, dis_p, busy} = 4'h0;
			pbuf.delete();
		end
		if (rd)
			drv = busy ? {~last_d[7], tog, last_d[5:0]}
				: (mem.exists(addr) ? mem[addr] : 8'hFF);
		else if (host_oe)
			drv = host_dq;
		else
			drv = ~drv;
	end
endmodule
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import eph_pkg::*;
	logic        clk, pready, pslverr, ce_n, oe_n, we_n, dq_oe, er;
	logic        rst = 1'b1, en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic [15:0] maddr, pg;
	logic [7:0]  dq_o, dq;
	logic [31:0] seed = 32'hB13C;
	logic [7:0]  exp_mem [int];
	int          fail_count = 0, n_compared = 0, r, i, n;

	eph_host #(.BLC_CYC(16'h0050), .WC_CYC(19'h007D0)) DUT (
		.clk(clk), .rst(rst), .en(en), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_addr(maddr), .mem_ce_n(ce_n), .mem_oe_n(oe_n), .mem_we_n(we_n),
		.mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .mem_dq_i(dq));
	eph_mem_model mdl (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(maddr),
		.host_dq(dq_o), .host_oe(dq_oe), .bus(dq));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] exp_rd(logic [15:0] a);
		return exp_mem.exists(a) ? exp_mem[a] : 8'hFF;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic op(input logic [1:0] c);
		int k;
		apb(1'b1, REG_CMD, {30'h0, c});
		for (k = 0; k < 4000; k++)
		begin
			apb(1'b0, REG_STATUS, 32'h0);
			if (rv[ST_BUSY] === 1'b0)
				break;
		end
		// A command that never finishes is a failure, not a silent skip
		if (k == 4000)
			fail_count++;
	endtask
	task automatic mwrite(input logic [15:0] a, input logic [7:0] d, input logic keep);
		apb(1'b1, REG_ADDR, {16'h0, a});
		apb(1'b1, REG_WDATA, {24'h0, d});
		op(2'h1);
		if (keep)
			exp_mem[a] = d;
	endtask
	task automatic mread(input logic [15:0] a);
		apb(1'b1, REG_ADDR, {16'h0, a});
		op(2'h2);
		check({24'h0, rv[23:16]}, {24'h0, exp_rd(a)});
	endtask

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Whole run needs well under 20000 cycles
	initial
	begin
		#(60000 * 25);
		fail_count++;
		complete_run();
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, REG_CTRL, 32'h0);
		check(rv, 32'h0);
		check({31'h0, er}, 32'h0);
		apb(1'b0, REG_STATUS, 32'h0);
		check(rv, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		check(rv, 32'h0);
		check({31'h0, er}, 32'h1);
		$display("test reset done");
		for (r = 0; r < 3; r++)
		begin
			pg = 16'h0800 | (16'(rnd()) & 16'h0F80);
			n = 2 + int'(rnd() % 6);
			for (i = 0; i < n; i++)
				mwrite(pg | 16'(i * 3), 8'(rnd()), 1'b1);
			apb(1'b0, REG_STATUS, 32'h0);
			check({24'h0, rv[15:8]}, 32'(n));
			for (i = 0; i < n; i++)
				mread(pg | 16'(i * 3));
		end
		$display("test random pages done");
		for (i = 0; i < 128; i++)
			mwrite(16'h1000 | 16'(i), 8'(rnd()), 1'b1);
		apb(1'b0, REG_STATUS, 32'h0);
		check({24'h0, rv[15:8]}, 32'h80);
		mwrite(16'h1005, 8'h3C, 1'b1);
		mwrite(16'h1100, 8'hC3, 1'b1);
		mread(16'h1000);
		mread(16'h107F);
		mread(16'h1005);
		mread(16'h1100);
		$display("test full page done");
		apb(1'b1, REG_ADDR, 32'h1200);
		apb(1'b1, REG_WDATA, 32'h77);
		op(2'h1);
		exp_mem[16'h1200] = 8'h77;
		apb(1'b1, REG_CMD, 32'h1);
		// Frozen by the clock enable, the queued write must not reach the pins
		en <= 1'b0;
		apb(1'b0, REG_STATUS, 32'h0);
		check({31'h0, ce_n}, 32'h1);
		en <= 1'b1;
		apb(1'b1, REG_ADDR, 32'h1300);
		op(2'h0);
		check({31'h0, rv[ST_ERR_BUSY]}, 32'h1);
		apb(1'b1, REG_STATUS, 32'h8);
		apb(1'b0, REG_ADDR, 32'h0);
		check(rv, 32'h1200);
		apb(1'b0, REG_STATUS, 32'h0);
		check({31'h0, rv[ST_ERR_BUSY]}, 32'h0);
		$display("test busy refusal done");
		apb(1'b1, REG_CTRL, 32'h1);
		mwrite(16'h1400, 8'h5E, 1'b1);
		op(2'h0);
		check({31'h0, mdl.prot}, 32'h1);
		mread(16'h5555);
		apb(1'b1, REG_CTRL, 32'h0);
		mwrite(16'h1480, 8'h11, 1'b0);
		mread(16'h1480);
		apb(1'b1, REG_CTRL, 32'h1);
		mwrite(16'h1480, 8'h22, 1'b1);
		mread(16'h1480);
		op(2'h3);
		op(2'h0);
		check({31'h0, mdl.prot}, 32'h0);
		apb(1'b1, REG_CTRL, 32'h0);
		mwrite(16'h1500, 8'h99, 1'b1);
		mread(16'h1500);
		$display("test protection done");
		complete_run();
	end
endmodule
`default_nettype wire
